// [rtl/vef_top.sv]
// vef_top: pixel filter select, colour controls, bars and level scaling
// assumes: AHB-Lite slave with hready wired back; pixel strobes are core-clock
// synchronous; standard pin is asynchronous and synchronised here
//
// What this block does
// - three-bit luma field selects luma response
// - three-bit chroma field selects chroma response
// - extended luma offers twelve gain variants
// - bar enable outputs standard colour bars
// - square pixel pin latched per field onto square_mode_out
// - chroma enable switches colour on/off
// - burst enable switches burst on/off
// - NTSC pedestal per line in blanking
// - contrast scales luma 75 to 125%
// - brightness adds onto scaled luma, pedestal
// - five-bit brightness, 32 steps, max 31
// - code 31 gives maximum setup level
// - two saturation fields scale U, V
// - hue offsets active subcarrier, not burst
// - hue range +-22 degrees, fine steps
// - y level bit swaps luma level sets
// - y scaling only on component output
// - two-bit field sets UV amplitude
// - standard pin high selects PAL
// - reset returns NTSC defaults
`timescale 1ns/1ps
`default_nettype none
module vef_top #(
   parameter int LINE_W = 10
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // pixel stream and timing
   input wire logic standard_select_pin_in,
   input wire logic square_pixel_in,
   input wire logic pix_valid_in,
   input wire vef_pkg::vef_pixel_t pix_in,
   input wire logic field_start_in,
   input wire logic field2_in,
   input wire logic [LINE_W-1:0] line_in,
   input wire logic active_in,
   input wire logic burst_gate_in,
   input wire logic [7:0] bar_index_in,
   output logic pix_valid_out,
   output vef_pkg::vef_pixel_t comp_out,
   output vef_pkg::vef_pixel_t yuv_out,
   output logic pedestal_on_out,
   output logic burst_on_out,
   output logic [8:0] hue_phase_out,
   output logic [2:0] luma_resp_out,
   output logic [2:0] chroma_resp_out,
   output logic [3:0] ext_gain_out,
   output logic [1:0] uv_amp_out,
   output logic pal_mode_out,
   output logic square_mode_out
);
   initial begin
      if (LINE_W < 10) $error("LINE_W must cover line 288");
   end

   // bus phase capture
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   vef_pkg::vef_cfg_t shadow_reg, live_reg;
   logic std_s1_reg, std_s2_reg;
   logic sq_s1_reg, sq_s2_reg;
   logic pal_reg, square_reg;

   wire addr_phase = hsel_in && hready_in && htrans_in[1];
   wire [7:0] reg_ofs = {haddr_in[7:2], 2'b00};
   wire do_write = wr_pend_reg;

   // read mux from shadow and live state
   logic [31:0] rd_word;
   always_comb begin
      rd_word = '0;
      case (reg_ofs)
         vef_pkg::OFS_MODE0: rd_word = {24'h0, shadow_reg.chroma_sel, shadow_reg.luma_sel, 2'b00};
         vef_pkg::OFS_MODE4: rd_word = {25'h0, shadow_reg.bars_en, shadow_reg.burst_en,
                                        shadow_reg.chroma_en, 4'h0};
         vef_pkg::OFS_MODE5: rd_word = {29'h0, shadow_reg.uv_level, shadow_reg.y_level};
         vef_pkg::OFS_CONTRAST: rd_word = {26'h0, shadow_reg.contrast};
         vef_pkg::OFS_BRIGHT: rd_word = {27'h0, shadow_reg.bright};
         vef_pkg::OFS_SAT_U: rd_word = {26'h0, shadow_reg.sat_u};
         vef_pkg::OFS_SAT_V: rd_word = {26'h0, shadow_reg.sat_v};
         vef_pkg::OFS_HUE: rd_word = {24'h0, shadow_reg.hue};
         vef_pkg::OFS_GAIN: rd_word = {28'h0, shadow_reg.ext_gain};
         vef_pkg::OFS_PED_F1: rd_word = {16'h0, shadow_reg.ped_f1};
         vef_pkg::OFS_PED_F2: rd_word = {16'h0, shadow_reg.ped_f2};
         vef_pkg::OFS_STATUS: rd_word = {24'h0, square_reg, pal_reg, live_reg.luma_sel,
                                         live_reg.chroma_sel};
         default: rd_word = '0;
      endcase
   end

   // write decode: reserved select codes keep the previous response
   wire [31:0] wd = hwdata_in;
   wire [2:0] wr_luma = wd[vef_pkg::LUMA_SEL_LSB +: 3];
   wire [2:0] wr_chroma = wd[vef_pkg::CHROMA_SEL_LSB +: 3];
   wire luma_ok = (wr_luma <= vef_pkg::LUMA_QCIF);
   wire chroma_ok = (wr_chroma <= vef_pkg::CHROMA_QCIF) &&
                    (wr_chroma != vef_pkg::CHROMA_RSVD);
   wire gain_ok = (wd[3:0] < vef_pkg::GAIN_STEPS);
   wire uv_ok = (wd[vef_pkg::UVLVL_LSB +: 2] != 2'h3);

   vef_pkg::vef_cfg_t shadow_next;
   always_comb begin
      shadow_next = shadow_reg;
      if (do_write) begin
         case (addr_reg)
            vef_pkg::OFS_MODE0: begin
               if (luma_ok) shadow_next.luma_sel = wr_luma;
               if (chroma_ok) shadow_next.chroma_sel = wr_chroma;
            end
            vef_pkg::OFS_MODE4: begin
               shadow_next.chroma_en = wd[vef_pkg::CHROMA_EN_BIT];
               shadow_next.burst_en = wd[vef_pkg::BURST_EN_BIT];
               shadow_next.bars_en = wd[vef_pkg::BARS_EN_BIT];
            end
            vef_pkg::OFS_MODE5: begin
               shadow_next.y_level = wd[vef_pkg::YLVL_BIT];
               if (uv_ok) shadow_next.uv_level = wd[vef_pkg::UVLVL_LSB +: 2];
            end
            vef_pkg::OFS_CONTRAST: shadow_next.contrast = wd[5:0];
            vef_pkg::OFS_BRIGHT: shadow_next.bright = wd[4:0];
            vef_pkg::OFS_SAT_U: shadow_next.sat_u = wd[5:0];
            vef_pkg::OFS_SAT_V: shadow_next.sat_v = wd[5:0];
            vef_pkg::OFS_HUE: shadow_next.hue = wd[7:0];
            vef_pkg::OFS_GAIN: if (gain_ok) shadow_next.ext_gain = wd[3:0];
            vef_pkg::OFS_PED_F1: shadow_next.ped_f1 = wd[15:0];
            vef_pkg::OFS_PED_F2: shadow_next.ped_f2 = wd[15:0];
            default: shadow_next = shadow_reg;
         endcase
      end
   end

   // reset defaults: NTSC, composite path, unity gains
   function automatic vef_pkg::vef_cfg_t cfg_default();
      vef_pkg::vef_cfg_t c;
      c = '0;
      c.luma_sel = vef_pkg::LUMA_NTSC_LP;
      c.chroma_en = vef_pkg::MODE4_RST[vef_pkg::CHROMA_EN_BIT];
      c.burst_en = vef_pkg::MODE4_RST[vef_pkg::BURST_EN_BIT];
      c.uv_level = vef_pkg::UV_DEFAULT;
      c.contrast = vef_pkg::CONTRAST_RST;
      c.sat_u = vef_pkg::SAT_RST;
      c.sat_v = vef_pkg::SAT_RST;
      c.hue = vef_pkg::HUE_RST;
      return c;
   endfunction

   // bus state, zero-wait: hreadyout always high, OKAY only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= '0;
         hrdata_out <= '0;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         wr_pend_reg <= addr_phase && hwrite_in;
         if (addr_phase) addr_reg <= reg_ofs;
         if (addr_phase && !hwrite_in) hrdata_out <= rd_word;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // shadow written any time, live copy taken at field start
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         shadow_reg <= cfg_default();
         live_reg <= cfg_default();
      end else begin
         shadow_reg <= shadow_next;
         if (field_start_in) live_reg <= shadow_next;
      end
   end

   // standard and square-pixel straps, two-flop synchronised
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         std_s1_reg <= 1'b0;
         std_s2_reg <= 1'b0;
         sq_s1_reg <= 1'b0;
         sq_s2_reg <= 1'b0;
         pal_reg <= 1'b0;
         square_reg <= 1'b0;
      end else begin
         std_s1_reg <= standard_select_pin_in;
         std_s2_reg <= std_s1_reg;
         sq_s1_reg <= square_pixel_in;
         sq_s2_reg <= sq_s1_reg;
         if (field_start_in) pal_reg <= std_s2_reg;
         if (field_start_in) square_reg <= sq_s2_reg;
      end
   end

   // pedestal window lookup per line
   wire [LINE_W-1:0] ped_base = field2_in ? LINE_W'(vef_pkg::PED_F2_FIRST) : LINE_W'(vef_pkg::PED_F1_FIRST);
   wire [LINE_W-1:0] ped_rel = line_in - ped_base;
   wire ped_in_win = (line_in >= ped_base) && (ped_rel < LINE_W'(vef_pkg::PED_LINES));
   wire [15:0] ped_bits = field2_in ? live_reg.ped_f2 : live_reg.ped_f1;
   wire ped_line = ped_in_win ? ped_bits[ped_rel[3:0]] : 1'b1;
   wire ped_now = !pal_reg && ped_line;

   // colour bar source: eight bars, first at full amplitude, Y steps down
   wire [2:0] bar = bar_index_in[7:5];
   wire [7:0] bar_top = pal_reg ? vef_pkg::BAR_Y_PAL : vef_pkg::BAR_Y_NTSC;
   wire [7:0] bar_y = 8'(bar_top - ((bar_top - vef_pkg::BLACK_CODE) >> 3) * bar);
   wire [7:0] bar_c = bar[0] ? 8'h40 : 8'hC0;
   vef_pkg::vef_pixel_t src;
   assign src = live_reg.bars_en ? '{y: bar_y, cb: bar_c, cr: ~bar_c} : pix_in;

   // contrast then brightness; factor = (192 + 2*code) / 256, code 0x20 is unity
   wire [9:0] k_con = vef_pkg::SCALE_BASE + {3'h0, live_reg.contrast, 1'b0};
   wire [17:0] y_mul = src.y * k_con;
   wire [8:0] y_scaled = y_mul[16:8];
   wire [8:0] y_ped = ped_now ? {1'b0, vef_pkg::PEDESTAL_CODE} : 9'h0;
   wire [8:0] y_sum = y_scaled + y_ped + {4'h0, live_reg.bright};
   wire [7:0] y_sat = y_sum[8] ? 8'hFF : y_sum[7:0];

   // saturation on each colour difference, around the 128 offset
   wire signed [8:0] cb_c = $signed({1'b0, src.cb}) - 9'sd128;
   wire signed [8:0] cr_c = $signed({1'b0, src.cr}) - 9'sd128;
   wire signed [10:0] k_u = $signed({1'b0, vef_pkg::SCALE_BASE}) + $signed({4'h0, live_reg.sat_u, 1'b0});
   wire signed [10:0] k_v = $signed({1'b0, vef_pkg::SCALE_BASE}) + $signed({4'h0, live_reg.sat_v, 1'b0});
   wire signed [19:0] cb_m = cb_c * k_u;
   wire signed [19:0] cr_m = cr_c * k_v;
   // back to offset binary, clipped: boost above unity can leave the code range
   wire signed [9:0] cb_b = $signed(cb_m[17:8]) + 10'sd128;
   wire signed [9:0] cr_b = $signed(cr_m[17:8]) + 10'sd128;
   wire [7:0] cb_o = !live_reg.chroma_en ? 8'd128 : cb_b[9] ? 8'h00 : cb_b[8] ? 8'hFF : cb_b[7:0];
   wire [7:0] cr_o = !live_reg.chroma_en ? 8'd128 : cr_b[9] ? 8'h00 : cr_b[8] ? 8'hFF : cr_b[7:0];

   // component luma swap: NTSC default SMPTE, PAL default other set
   wire y_alt = pal_reg ^ live_reg.y_level;
   wire [8:0] y_cmp_m = {1'b0, y_sat} + (y_alt ? 9'h0 : {4'h0, y_sat[7:3]} >> 2);
   wire [7:0] y_cmp = y_cmp_m[8] ? 8'hFF : y_cmp_m[7:0];

   // hue offset only in active video; burst keeps reference phase
   wire [8:0] hue_off = {live_reg.hue, 1'b0} - {vef_pkg::HUE_RST, 1'b0};
   wire [8:0] hue_next = active_in ? hue_off : 9'h0;

   // uv amplitude code actually applied
   wire [1:0] uv_next = live_reg.uv_level;

   // output stage
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pix_valid_out <= 1'b0;
         comp_out <= '0;
         yuv_out <= '0;
         pedestal_on_out <= 1'b0;
         burst_on_out <= 1'b0;
         hue_phase_out <= '0;
         luma_resp_out <= vef_pkg::LUMA_NTSC_LP;
         chroma_resp_out <= '0;
         ext_gain_out <= '0;
         uv_amp_out <= vef_pkg::UV_DEFAULT;
         pal_mode_out <= 1'b0;
         square_mode_out <= 1'b0;
      end else begin
         pix_valid_out <= pix_valid_in;
         if (pix_valid_in) begin
            comp_out <= '{y: y_sat, cb: cb_o, cr: cr_o};
            yuv_out <= '{y: y_cmp, cb: cb_o, cr: cr_o};
         end
         pedestal_on_out <= ped_now;
         burst_on_out <= burst_gate_in && live_reg.burst_en && live_reg.chroma_en;
         hue_phase_out <= hue_next;
         luma_resp_out <= live_reg.luma_sel;
         chroma_resp_out <= live_reg.chroma_sel;
         ext_gain_out <= (live_reg.luma_sel == vef_pkg::LUMA_EXT) ? live_reg.ext_gain : 4'h0;
         uv_amp_out <= uv_next;
         pal_mode_out <= pal_reg;
         square_mode_out <= square_reg;
      end
   end

   // assertions
   sequence s_burst_req;
      burst_gate_in && live_reg.burst_en && live_reg.chroma_en;
   endsequence

   a_burst_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
      s_burst_req |=> burst_on_out) else $error("burst not passed");
   a_burst_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !live_reg.burst_en |=> !burst_on_out) else $error("burst leaked");
   a_chroma_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (pix_valid_in && !live_reg.chroma_en) |=> (comp_out.cb == 8'd128 && comp_out.cr == 8'd128))
      else $error("chroma not removed");
   a_live_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !field_start_in |=> live_reg == $past(live_reg)) else $error("settings changed mid field");
   a_pal_pin: assert property (@(posedge core_clk_in) disable iff (rst_in)
      field_start_in |=> pal_reg == $past(std_s2_reg)) else $error("standard not taken");
   a_hue_blank: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !active_in |=> hue_phase_out == 9'h0) else $error("hue in blanking");
   a_luma_rsvd: assert property (@(posedge core_clk_in) disable iff (rst_in)
      shadow_reg.luma_sel <= vef_pkg::LUMA_QCIF) else $error("luma select reserved");
   a_chroma_rsvd: assert property (@(posedge core_clk_in) disable iff (rst_in)
      shadow_reg.chroma_sel != vef_pkg::CHROMA_RSVD) else $error("chroma select reserved");
   a_gain_range: assert property (@(posedge core_clk_in) disable iff (rst_in)
      shadow_reg.ext_gain < vef_pkg::GAIN_STEPS) else $error("gain out of range");
   a_ped_pal: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pal_reg |=> !pedestal_on_out) else $error("pedestal in PAL");
endmodule
`default_nettype wire

// [pkg/vef_pkg.sv]
// vef_pkg: shared constants and types of the encoder pixel-control block
// assumes: 32-bit AHB-Lite register access, one 250 MHz core clock
package vef_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_MODE0 = 8'h00; // luma/chroma filter select
   localparam logic [7:0] OFS_MODE4 = 8'h04; // chroma, burst, bars
   localparam logic [7:0] OFS_MODE5 = 8'h08; // yuv levels
   localparam logic [7:0] OFS_CONTRAST = 8'h0C;
   localparam logic [7:0] OFS_BRIGHT = 8'h10;
   localparam logic [7:0] OFS_SAT_U = 8'h14;
   localparam logic [7:0] OFS_SAT_V = 8'h18;
   localparam logic [7:0] OFS_HUE = 8'h1C;
   localparam logic [7:0] OFS_GAIN = 8'h20;
   localparam logic [7:0] OFS_PED_F1 = 8'h24;
   localparam logic [7:0] OFS_PED_F2 = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;
   // field positions
   localparam int LUMA_SEL_LSB = 2;
   localparam int CHROMA_SEL_LSB = 5;
   localparam int CHROMA_EN_BIT = 4;
   localparam int BURST_EN_BIT = 5;
   localparam int BARS_EN_BIT = 6;
   localparam int YLVL_BIT = 0;
   localparam int UVLVL_LSB = 1;
   // encodings
   localparam logic [2:0] LUMA_NTSC_LP = 3'h0;
   localparam logic [2:0] LUMA_PAL_LP = 3'h1;
   localparam logic [2:0] LUMA_EXT = 3'h4;
   localparam logic [2:0] LUMA_QCIF = 3'h6;
   localparam logic [2:0] CHROMA_RSVD = 3'h4;
   localparam logic [2:0] CHROMA_QCIF = 3'h6;
   localparam logic [1:0] UV_DEFAULT = 2'h0;
   localparam logic [1:0] UV_700 = 2'h1;
   localparam logic [1:0] UV_1000 = 2'h2;
   localparam logic [3:0] GAIN_STEPS = 4'hC;
   // reset values
   localparam logic [5:0] CONTRAST_RST = 6'h20; // unity
   localparam logic [5:0] SAT_RST = 6'h20;
   localparam logic [7:0] HUE_RST = 8'h80; // zero offset
   localparam logic [31:0] MODE4_RST = 32'h0000_0030; // chroma+burst on
   // per-line pedestal windows
   localparam logic [9:0] PED_F1_FIRST = 10'd10;
   localparam logic [9:0] PED_F2_FIRST = 10'd273;
   localparam int PED_LINES = 16;
   // datapath scale factors, q.8 on contrast/sat from 0.75..1.25 over 64 codes
   localparam logic [9:0] SCALE_BASE = 10'd192;
   localparam logic [7:0] PEDESTAL_CODE = 8'd16;
   localparam logic [7:0] BLACK_CODE = 8'd16;
   // colour bar amplitudes (code units)
   localparam logic [7:0] BAR_Y_NTSC = 8'd180;
   localparam logic [7:0] BAR_Y_PAL = 8'd235;

   typedef struct packed {
      logic [7:0] y;
      logic [7:0] cb;
      logic [7:0] cr;
   } vef_pixel_t;

   typedef struct packed {
      logic [2:0] luma_sel;
      logic [2:0] chroma_sel;
      logic [3:0] ext_gain;
      logic chroma_en;
      logic burst_en;
      logic bars_en;
      logic y_level;
      logic [1:0] uv_level;
      logic [5:0] contrast;
      logic [4:0] bright;
      logic [5:0] sat_u;
      logic [5:0] sat_v;
      logic [7:0] hue;
      logic [15:0] ped_f1;
      logic [15:0] ped_f2;
   } vef_cfg_t;
endpackage

// [bench/vef_host_model.sv]
// vef_host_model: host side of the register bus, single-word AHB-Lite transfers
// assumes: one slave whose hreadyout is fed back as hready_in
`timescale 1ns/1ps
`default_nettype none
module vef_host_model (
   input wire logic clk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out
);
   // bus idle at time zero
   initial begin
      hsel_out = 1'b1;
      haddr_out = 32'h0000_0000;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0000_0000;
   end
   // address phase held until hready, then data phase held until hready
   task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_in);
      htrans_out <= 2'h2;
      haddr_out <= {24'h00_0000, ofs};
      hwrite_out <= wr;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      do @(posedge clk_in); while (hready_in !== 1'b1);
      rd = hrdata_in;
      hwdata_out <= ~wd; // released data must not linger
   endtask
   // register write
   task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
      logic [31:0] unused;
      xfer(1'b1, ofs, wd, unused);
   endtask
   // register read
   task automatic rd(input logic [7:0] ofs, output logic [31:0] rdv);
      xfer(1'b0, ofs, 32'h0000_0000, rdv);
   endtask
endmodule
`default_nettype wire

// [bench/test_video_encoder_filter_color_ctrl.sv]
// test_video_encoder_filter_color_ctrl: scenario bench for vef_top
// assumes: host model drives the bus; bench drives pixel and timing inputs
`timescale 1ns/1ps
`default_nettype none
module test_video_encoder_filter_color_ctrl;
   logic clk, rst, hsel, hwrite, hready, hresp, std_pin, sq, fs, f2, act, gate;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans, uv_amp;
   logic [2:0] hsize, luma_resp, chroma_resp, c, pl, pc;
   logic [9:0] line;
   logic [7:0] bar;
   logic [8:0] hue_ph;
   logic [3:0] ext_gain, pg;
   logic pv, pv_o, ped_on, burst_on, pal_mode, sq_mode;
   vef_pkg::vef_pixel_t pix, comp, yuv, a, b, cc, d, yb, yc;
   int fails, total_checks;
   vef_host_model host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
      .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
   vef_top dut (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .standard_select_pin_in(std_pin), .square_pixel_in(sq),
      .pix_valid_in(pv), .pix_in(pix), .field_start_in(fs), .field2_in(f2), .line_in(line), .active_in(act),
      .burst_gate_in(gate), .bar_index_in(bar), .pix_valid_out(pv_o), .comp_out(comp), .yuv_out(yuv),
      .pedestal_on_out(ped_on), .burst_on_out(burst_on), .hue_phase_out(hue_ph), .luma_resp_out(luma_resp),
      .chroma_resp_out(chroma_resp), .ext_gain_out(ext_gain), .uv_amp_out(uv_amp), .pal_mode_out(pal_mode),
      .square_mode_out(sq_mode));
   // 250 MHz core clock
   always #2 clk = ~clk;
   // value compare
   task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // flag compare
   task automatic chk_flag(string nm, logic e, logic g);
      chk_val(nm, 32'(e), 32'(g));
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle field start pulse, then let live settings reach the outputs
   task automatic new_field();
      @(posedge clk);
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      settle(2);
   endtask
   // hold a timing/pixel condition for a few cycles
   task automatic px(logic sf2, logic [9:0] ln, logic sact, logic sgate);
      @(posedge clk);
      f2 <= sf2;
      line <= ln;
      act <= sact;
      gate <= sgate;
      settle(3);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // defaults after reset, unmapped read
   task automatic t_reset();
      chk_flag("hreadyout", 1'b1, hready);
      chk_flag("hresp", 1'b0, hresp);
      chk_flag("pal_mode", 1'b0, pal_mode);
      chk_val("luma_resp", 32'(vef_pkg::LUMA_NTSC_LP), 32'(luma_resp));
      host.rd(vef_pkg::OFS_MODE4, r);
      chk_val("mode4", vef_pkg::MODE4_RST, r);
      host.rd(vef_pkg::OFS_CONTRAST, r);
      chk_val("contrast", 32'(vef_pkg::CONTRAST_RST), r);
      host.rd(vef_pkg::OFS_HUE, r);
      chk_val("hue", 32'(vef_pkg::HUE_RST), r);
      host.rd(8'h40, r);
      chk_val("unmapped", 32'h0000_0000, r);
      $display("t_reset done");
   endtask
   // every luma and chroma code; reserved codes keep the previous response
   task automatic t_filters();
      pl = 3'h0;
      pc = 3'h0;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         host.wr(vef_pkg::OFS_MODE0, 32'({c, c, 2'h0}));
         settle(2);
         chk_val("luma before field", 32'(pl), 32'(luma_resp));
         new_field();
         if (c != 3'h7) pl = c;
         if (c != vef_pkg::CHROMA_RSVD && c != 3'h7) pc = c;
         chk_val("luma_resp", 32'(pl), 32'(luma_resp));
         chk_val("chroma_resp", 32'(pc), 32'(chroma_resp));
      end
      $display("t_filters done");
   endtask
   // extended response gain steps, out-of-range ignored
   task automatic t_gain();
      int gs [4] = '{0, 11, 12, 15};
      pg = 4'h0;
      host.wr(vef_pkg::OFS_MODE0, 32'({3'h0, vef_pkg::LUMA_EXT, 2'h0}));
      for (int i = 0; i < 4; i++) begin
         host.wr(vef_pkg::OFS_GAIN, 32'(gs[i]));
         new_field();
         if (gs[i] < 12) pg = 4'(gs[i]);
         chk_val("ext_gain", 32'(pg), 32'(ext_gain));
      end
      $display("t_gain done");
   endtask
   // uv level codes; code 3 ignored
   task automatic t_uv();
      logic [1:0] pu;
      pu = 2'h0;
      for (int u = 0; u < 4; u++) begin
         host.wr(vef_pkg::OFS_MODE5, 32'(u * 2));
         new_field();
         if (u != 3) pu = 2'(u);
         chk_val("uv_amp", 32'(pu), 32'(uv_amp));
      end
      $display("t_uv done");
   endtask
   // burst switched by its own bit and by chroma enable
   task automatic t_burst();
      logic [7:0] m4 [4] = '{8'h30, 8'h10, 8'h20, 8'h30};
      logic [3:0] gt = 4'h7;
      logic [3:0] ex = 4'h1;
      for (int i = 0; i < 4; i++) begin
         host.wr(vef_pkg::OFS_MODE4, 32'(m4[i]));
         new_field();
         px(1'b0, 10'd100, 1'b0, gt[i]);
         chk_flag("burst_on", ex[i], burst_on);
      end
      $display("t_burst done");
   endtask
   // standard pin, square mode, bars in both standards
   task automatic t_std_bars();
      host.wr(vef_pkg::OFS_MODE4, 32'h0000_0070);
      bar <= 8'h00;
      for (int s = 1; s >= 0; s--) begin
         std_pin <= 1'(s);
         sq <= 1'(s);
         settle(4);
         new_field();
         px(1'b0, 10'd100, 1'b1, 1'b0);
         chk_flag("pal_mode", 1'(s), pal_mode);
         chk_flag("square_mode", 1'(s), sq_mode);
         chk_val("bar y", s ? 32'(vef_pkg::BAR_Y_PAL) : 32'(vef_pkg::BAR_Y_NTSC) + 32'(vef_pkg::PEDESTAL_CODE),
            32'(comp.y));
      end
      host.wr(vef_pkg::OFS_MODE4, vef_pkg::MODE4_RST);
      $display("t_std_bars done");
   endtask
   // per-line pedestal at both window ends and outside
   task automatic t_ped();
      logic [9:0] ln [6] = '{10'd10, 10'd11, 10'd25, 10'd9, 10'd288, 10'd273};
      logic [5:0] fl = 6'h30;
      logic [5:0] ex = 6'h2E;
      host.wr(vef_pkg::OFS_PED_F1, 32'h0000_FFFE);
      host.wr(vef_pkg::OFS_PED_F2, 32'h0000_7FFF);
      new_field();
      for (int i = 0; i < 6; i++) begin
         px(fl[i], ln[i], 1'b1, 1'b0);
         chk_flag("pedestal_on", ex[i], ped_on);
      end
      $display("t_ped done");
   endtask
   // contrast, saturation, brightness and y level on composite path
   task automatic t_color();
      pix <= 24'h78_C83C;
      px(1'b0, 10'd10, 1'b1, 1'b0);
      for (int k = 0; k < 4; k++) begin
         host.wr(vef_pkg::OFS_CONTRAST, k ? 32'h0000_003F : 32'h0000_0000);
         host.wr(vef_pkg::OFS_SAT_U, k ? 32'h0000_003F : 32'h0000_0000);
         host.wr(vef_pkg::OFS_SAT_V, k ? 32'h0000_003F : 32'h0000_0000);
         host.wr(vef_pkg::OFS_MODE5, 32'(k > 1));
         host.wr(vef_pkg::OFS_BRIGHT, (k == 3) ? 32'h0000_001F : 32'h0000_0000);
         new_field();
         settle(2);
         case (k)
            0: a = comp;
            1: begin
               b = comp;
               yb = yuv;
            end
            2: begin
               cc = comp;
               yc = yuv;
            end
            default: d = comp;
         endcase
      end
      chk_flag("contrast up", 1'b1, b.y > a.y);
      chk_flag("sat u up", 1'b1, b.cb > a.cb);
      chk_flag("sat v up", 1'b1, b.cr < a.cr);
      chk_val("comp under y level", 32'(b), 32'(cc));
      chk_flag("bright up", 1'b1, d.y > cc.y);
      chk_flag("yuv y level", 1'b1, yb.y != yc.y);
      chk_val("yuv chroma", 32'(b.cb), 32'(yb.cb));
      @(posedge clk);
      pv <= 1'b0;
      settle(2);
      chk_flag("pix_valid", 1'b0, pv_o);
      @(posedge clk);
      pv <= 1'b1;
      $display("t_color done");
   endtask
   // hue offset only in active video, sign follows code
   task automatic t_hue();
      host.wr(vef_pkg::OFS_HUE, 32'h0000_0090);
      new_field();
      px(1'b0, 10'd100, 1'b1, 1'b0);
      chk_flag("hue nonzero", 1'b1, hue_ph != 9'h000);
      chk_flag("hue sign", 1'b0, hue_ph[8]);
      px(1'b0, 10'd100, 1'b0, 1'b1);
      chk_val("hue in burst", 32'h0000_0000, 32'(hue_ph));
      host.wr(vef_pkg::OFS_HUE, 32'h0000_0070);
      new_field();
      px(1'b0, 10'd100, 1'b1, 1'b0);
      chk_flag("hue sign", 1'b1, hue_ph[8]);
      $display("t_hue done");
   endtask
   // second reset in mid-run
   task automatic t_rerun();
      @(posedge clk);
      rst <= 1'b1;
      settle(2);
      chk_val("luma_resp", 32'h0000_0000, 32'(luma_resp));
      @(posedge clk);
      rst <= 1'b0;
      host.rd(vef_pkg::OFS_MODE0, r);
      chk_val("mode0", 32'h0000_0000, r);
      $display("t_rerun done");
   endtask
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {std_pin, sq, fs, f2, act, gate} = 6'h00;
      pv = 1'b1;
      line = 10'd100;
      bar = 8'h00;
      pix = 24'h80_8080;
      fails = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      settle(1);
      t_reset();
      t_filters();
      t_gain();
      t_uv();
      t_burst();
      t_std_bars();
      t_ped();
      t_color();
      t_hue();
      t_rerun();
      conclude();
   end
   // watchdog
   initial begin
      #100000;
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
